//--- logic/rrr_defines.svh
`ifndef RRR_DEFINES_SVH
`define RRR_DEFINES_SVH

// Program counter width
`define RRR_PC_W 15
// Register offsets on the Wishbone bus (byte addresses)
`define RRR_OFS_WORK 8'h00
`define RRR_OFS_STATUS 8'h04
`define RRR_OFS_INTCTL 8'h08
`define RRR_OFS_PWRCTL 8'h0c
`define RRR_OFS_PC 8'h10
`define RRR_OFS_CORE 8'h14
// Field positions
`define RRR_BIT_CARRY 0
`define RRR_BIT_DCARRY 1
`define RRR_BIT_ZERO 2
`define RRR_BIT_GLB_IE 7
`define RRR_BIT_RST_INSTR 2
`define RRR_BIT_BUSY 0
// Reset values
`define RRR_RST_WORK 8'h00
`define RRR_RST_INTCTL 8'h00
`define RRR_RST_PC 15'h0000
// Reset instruction flag reads 1 after a hardware reset
`define RRR_RST_RST_INSTR 1'b1

`endif

//--- logic/rrr_pkg.sv
package rrr_pkg;
  `include "rrr_defines.svh"

  // Operation handed over by the decode stage
  typedef enum logic [6:0] {
    RRR_OP_NONE = 7'h01,
    RRR_OP_SW_RESET = 7'h02,
    RRR_OP_RET_INT = 7'h04,
    RRR_OP_RET_SUB = 7'h08,
    RRR_OP_RET_LIT = 7'h10,
    RRR_OP_ROT_LEFT = 7'h20,
    RRR_OP_ROT_RIGHT = 7'h40
  } rrr_op_t;

  // Sequencer states, one-hot
  typedef enum logic [1:0] {
    RRR_ST_IDLE = 2'h1,
    RRR_ST_FLUSH = 2'h2
  } rrr_state_t;

  // Whole state of the executor
  typedef struct packed {
    rrr_state_t st;
    logic [7:0] work;
    logic carry;
    logic dcarry;
    logic zero;
    logic [7:0] intctl;
    logic rst_instr;
    logic [`RRR_PC_W-1:0] pc;
    logic pc_load;
    logic pop;
    logic fwe;
    logic [6:0] faddr;
    logic [7:0] fdata;
    logic swrst;
    logic ack;
    logic [31:0] rdata;
  } rrr_regs_t;
endpackage

//--- logic/rrr_rot_if.sv
`timescale 1ns/1ps
// Rotate-through-carry request and result
interface rrr_rot_if;
  logic left; // High rotates left, low rotates right
  logic [7:0] din; // Operand
  logic cin; // Old carry
  logic [7:0] dout; // Rotated value
  logic cout; // New carry
  modport core (output left, output din, output cin,
                input dout, input cout);
  modport unit (input left, input din, input cin,
                output dout, output cout);
endinterface

//--- logic/rrr_rotator.sv
`timescale 1ns/1ps
// Rotates one byte by one place through the carry
module rrr_rotator (
  rrr_rot_if.unit rot
);
  import rrr_pkg::*;

  // Pure combinational rotate
  always_comb begin
    if (rot.left) begin
      // Old carry enters bit 0, old bit 7 leaves
      rot.dout = {rot.din[6:0], rot.cin};
      rot.cout = rot.din[7];
    end else begin
      // Old carry enters bit 7, old bit 0 leaves
      rot.dout = {rot.cin, rot.din[7:1]};
      rot.cout = rot.din[0];
    end
  end
endmodule

//--- logic/rrr_exec.sv
`timescale 1ns/1ps
`include "rrr_defines.svh"
module rrr_exec (
  input wire logic clk_i,
  input wire logic rst_i,
  // Decode stage
  input wire logic instr_valid_i,
  input wire rrr_pkg::rrr_op_t op_i,
  input wire logic [7:0] literal_i,
  input wire logic [6:0] faddr_i,
  input wire logic dest_i,
  input wire logic [7:0] file_data_i,
  output logic ready_o,
  // Return stack
  input wire logic [`RRR_PC_W-1:0] stack_top_i,
  output logic stack_pop_o,
  // Program counter
  output logic pc_load_o,
  output logic [`RRR_PC_W-1:0] pc_o,
  // File register write port
  output logic file_we_o,
  output logic [6:0] file_addr_o,
  output logic [7:0] file_wdata_o,
  // Core state
  output logic [7:0] work_o,
  output logic carry_o,
  output logic glb_ie_o,
  output logic soft_reset_o,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);
  import rrr_pkg::*;

  rrr_regs_t q; // Current state
  rrr_regs_t d; // Next state
  rrr_regs_t rst_val; // Value after a hardware reset
  logic accept; // Instruction taken this cycle
  logic bus_req; // New bus access this cycle
  logic bus_wr; // New bus write to the low byte
  logic [31:0] keep_rdata; // Read data of this cycle's bus access
  logic sw_take; // Software reset taken this cycle
  rrr_rot_if rot(); // Link to the rotator

  // Rotator sees the addressed file register and the old carry
  assign rot.left = (op_i == RRR_OP_ROT_LEFT);
  assign rot.din = file_data_i;
  assign rot.cin = q.carry;

  rrr_rotator u_rot (
    .rot(rot)
  );

  // Reset image shared by hardware and software reset
  always_comb begin
    rst_val = '0;
    rst_val.st = RRR_ST_IDLE;
    rst_val.work = `RRR_RST_WORK;
    rst_val.intctl = `RRR_RST_INTCTL;
    rst_val.rst_instr = `RRR_RST_RST_INSTR;
    rst_val.pc = `RRR_RST_PC;
  end

  // Handshakes
  assign ready_o = (q.st == RRR_ST_IDLE);
  assign accept = instr_valid_i && ready_o;
  assign bus_req = wb_cyc_i && wb_stb_i && !q.ack;
  assign bus_wr = bus_req && wb_we_i && wb_sel_i[0];
  assign sw_take = accept && (op_i == RRR_OP_SW_RESET);

  // Next state
  always_comb begin
    d = q;
    d.pc_load = 1'b0;
    d.pop = 1'b0;
    d.fwe = 1'b0;
    d.swrst = 1'b0;
    d.ack = 1'b0;
    // Bus access, answered one cycle later
    if (bus_req) begin
      d.ack = 1'b1;
      d.rdata = 32'h0000_0000;
      if (wb_adr_i == `RRR_OFS_WORK) begin
        d.rdata[7:0] = q.work;
      end else if (wb_adr_i == `RRR_OFS_STATUS) begin
        d.rdata[`RRR_BIT_CARRY] = q.carry;
        d.rdata[`RRR_BIT_DCARRY] = q.dcarry;
        d.rdata[`RRR_BIT_ZERO] = q.zero;
      end else if (wb_adr_i == `RRR_OFS_INTCTL) begin
        d.rdata[7:0] = q.intctl;
      end else if (wb_adr_i == `RRR_OFS_PWRCTL) begin
        d.rdata[`RRR_BIT_RST_INSTR] = q.rst_instr;
      end else if (wb_adr_i == `RRR_OFS_PC) begin
        d.rdata[`RRR_PC_W-1:0] = q.pc;
      end else if (wb_adr_i == `RRR_OFS_CORE) begin
        d.rdata[`RRR_BIT_BUSY] = (q.st != RRR_ST_IDLE);
      end
      // Writes touch the low byte only
      if (bus_wr) begin
        if (wb_adr_i == `RRR_OFS_WORK) begin
          d.work = wb_dat_i[7:0];
        end else if (wb_adr_i == `RRR_OFS_STATUS) begin
          d.carry = wb_dat_i[`RRR_BIT_CARRY];
          d.dcarry = wb_dat_i[`RRR_BIT_DCARRY];
          d.zero = wb_dat_i[`RRR_BIT_ZERO];
        end else if (wb_adr_i == `RRR_OFS_INTCTL) begin
          d.intctl = wb_dat_i[7:0];
        end else if (wb_adr_i == `RRR_OFS_PWRCTL) begin
          d.rst_instr = wb_dat_i[`RRR_BIT_RST_INSTR];
        end
      end
    end
    // Kept so a software reset still answers a read with fresh data
    keep_rdata = d.rdata;
    // Instruction execution overrides a bus write in the same cycle
    case (q.st)
      RRR_ST_IDLE: begin
        if (instr_valid_i) begin
          case (op_i)
            RRR_OP_SW_RESET: begin
              // Core back to reset image, reset instruction flag cleared
              d = rst_val;
              d.swrst = 1'b1;
              d.rst_instr = 1'b0;
              d.ack = bus_req;
              d.rdata = keep_rdata;
            end
            RRR_OP_RET_INT: begin
              // Pop, load PC, re-enable interrupts
              d.pop = 1'b1;
              d.pc = stack_top_i;
              d.pc_load = 1'b1;
              d.intctl[`RRR_BIT_GLB_IE] = 1'b1;
              d.st = RRR_ST_FLUSH;
            end
            RRR_OP_RET_SUB: begin
              // Pop and load PC, enable left as is
              d.pop = 1'b1;
              d.pc = stack_top_i;
              d.pc_load = 1'b1;
              d.st = RRR_ST_FLUSH;
            end
            RRR_OP_RET_LIT: begin
              // Literal into work register, then return
              d.work = literal_i;
              d.pop = 1'b1;
              d.pc = stack_top_i;
              d.pc_load = 1'b1;
              d.st = RRR_ST_FLUSH;
            end
            RRR_OP_ROT_LEFT, RRR_OP_ROT_RIGHT: begin
              // Single cycle, only carry among status bits
              d.carry = rot.cout;
              if (dest_i) begin
                // Result back into the file register
                d.fwe = 1'b1;
                d.faddr = faddr_i;
                d.fdata = rot.dout;
              end else begin
                // Result into the work register
                d.work = rot.dout;
              end
            end
            default: begin
              d.st = RRR_ST_IDLE;
            end
          endcase
        end
      end
      RRR_ST_FLUSH: begin
        // Second cycle of a return, fetch refills
        d.st = RRR_ST_IDLE;
      end
      default: begin
        d.st = RRR_ST_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= rst_val;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from flip-flops
  assign stack_pop_o = q.pop;
  assign pc_load_o = q.pc_load;
  assign pc_o = q.pc;
  assign file_we_o = q.fwe;
  assign file_addr_o = q.faddr;
  assign file_wdata_o = q.fdata;
  assign work_o = q.work;
  assign carry_o = q.carry;
  assign glb_ie_o = q.intctl[`RRR_BIT_GLB_IE];
  assign soft_reset_o = q.swrst;
  assign wb_ack_o = q.ack;
  assign wb_dat_o = q.rdata;

  // Software reset pulses and restores the reset image
  property p_sw_reset;
    @(posedge clk_i) disable iff (rst_i)
    sw_take |=>
      soft_reset_o && pc_o == `RRR_RST_PC && work_o == `RRR_RST_WORK
      ##1 (!soft_reset_o || $past(sw_take));
  endproperty
  a_sw_reset: assert property (p_sw_reset)
    else $error("software reset image wrong");

  // Software reset leaves the flag cleared
  property p_rst_flag;
    @(posedge clk_i) disable iff (rst_i)
    accept && op_i == RRR_OP_SW_RESET |=> !q.rst_instr;
  endproperty
  a_rst_flag: assert property (p_rst_flag)
    else $error("reset instruction flag not cleared");

  // Interrupt return pops into PC and holds off for one cycle
  property p_ret_int;
    @(posedge clk_i) disable iff (rst_i)
    accept && op_i == RRR_OP_RET_INT |=>
      stack_pop_o && pc_o == $past(stack_top_i) && !ready_o
      ##1 ready_o && !stack_pop_o;
  endproperty
  a_ret_int: assert property (p_ret_int)
    else $error("interrupt return timing or PC wrong");

  // Interrupt return enables interrupts
  property p_glb_ie;
    @(posedge clk_i) disable iff (rst_i)
    accept && op_i == RRR_OP_RET_INT |=> glb_ie_o;
  endproperty
  a_glb_ie: assert property (p_glb_ie)
    else $error("interrupt enable not set");

  // Subroutine return keeps the enable and takes two cycles
  property p_ret_sub;
    @(posedge clk_i) disable iff (rst_i)
    accept && op_i == RRR_OP_RET_SUB && !bus_wr |=>
      glb_ie_o == $past(glb_ie_o) && pc_o == $past(stack_top_i)
      && !ready_o ##1 ready_o;
  endproperty
  a_ret_sub: assert property (p_ret_sub)
    else $error("subroutine return wrong");

  // Literal return loads work register and PC
  property p_ret_lit;
    @(posedge clk_i) disable iff (rst_i)
    accept && op_i == RRR_OP_RET_LIT |=>
      work_o == $past(literal_i) && pc_load_o && !ready_o;
  endproperty
  a_ret_lit: assert property (p_ret_lit)
    else $error("literal return wrong");

  // Left rotate result and carry
  property p_rot_left;
    @(posedge clk_i) disable iff (rst_i)
    accept && op_i == RRR_OP_ROT_LEFT && !dest_i |=>
      carry_o == $past(file_data_i[7])
      && work_o == {$past(file_data_i[6:0]), $past(carry_o)};
  endproperty
  a_rot_left: assert property (p_rot_left)
    else $error("left rotate wrong");

  // Right rotate result and carry
  property p_rot_right;
    @(posedge clk_i) disable iff (rst_i)
    accept && op_i == RRR_OP_ROT_RIGHT && dest_i |=>
      carry_o == $past(file_data_i[0]) && file_we_o
      && file_wdata_o == {$past(carry_o), $past(file_data_i[7:1])};
  endproperty
  a_rot_right: assert property (p_rot_right)
    else $error("right rotate wrong");

  // Destination bit steers the result
  property p_dest;
    @(posedge clk_i) disable iff (rst_i)
    accept && (op_i == RRR_OP_ROT_LEFT || op_i == RRR_OP_ROT_RIGHT)
    |=> file_we_o == $past(dest_i)
      && (!file_we_o || file_addr_o == $past(faddr_i));
  endproperty
  a_dest: assert property (p_dest)
    else $error("rotate destination wrong");

  // Rotate keeps zero and digit carry, stays ready
  property p_rot_flags;
    @(posedge clk_i) disable iff (rst_i)
    accept && (op_i == RRR_OP_ROT_LEFT || op_i == RRR_OP_ROT_RIGHT)
    && !bus_wr |=> $stable(q.zero) && $stable(q.dcarry) && ready_o;
  endproperty
  a_rot_flags: assert property (p_rot_flags)
    else $error("rotate touched other flags");

  c_ret_int: cover property (@(posedge clk_i) disable iff (rst_i)
    accept && op_i == RRR_OP_RET_INT);
  c_ret_lit: cover property (@(posedge clk_i) disable iff (rst_i)
    accept && op_i == RRR_OP_RET_LIT);
  c_rot_file: cover property (@(posedge clk_i) disable iff (rst_i)
    accept && op_i == RRR_OP_ROT_LEFT && dest_i);
  c_sw_reset: cover property (@(posedge clk_i) disable iff (rst_i)
    accept && op_i == RRR_OP_SW_RESET);
endmodule

//--- testbench/rrr_tb.sv
`timescale 1ns/1ps
`include "rrr_defines.svh"
module tb;
  import rrr_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic instr_valid_i = 1'b0;
  rrr_op_t op_i = RRR_OP_NONE;
  logic [7:0] literal_i = 8'h00;
  logic [6:0] faddr_i = 7'h00;
  logic dest_i = 1'b0;
  logic [7:0] file_data_i = 8'h00;
  logic [`RRR_PC_W-1:0] stack_top_i = 15'h0000;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic ready_o, stack_pop_o, pc_load_o, file_we_o, carry_o, glb_ie_o;
  logic soft_reset_o, wb_ack_o;
  logic [`RRR_PC_W-1:0] pc_o;
  logic [6:0] file_addr_o;
  logic [7:0] file_wdata_o, work_o;
  int n_errors = 0;
  int cmp_count = 0;

  // Free-running 100 MHz clock
  always #5 clk_i = ~clk_i;

  rrr_exec dut (.clk_i(clk_i), .rst_i(rst_i), .instr_valid_i(instr_valid_i),
    .op_i(op_i), .literal_i(literal_i), .faddr_i(faddr_i), .dest_i(dest_i),
    .file_data_i(file_data_i), .ready_o(ready_o), .stack_top_i(stack_top_i),
    .stack_pop_o(stack_pop_o), .pc_load_o(pc_load_o), .pc_o(pc_o),
    .file_we_o(file_we_o), .file_addr_o(file_addr_o),
    .file_wdata_o(file_wdata_o), .work_o(work_o), .carry_o(carry_o),
    .glb_ie_o(glb_ie_o), .soft_reset_o(soft_reset_o), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o));

  // Compare one value, count it, report a difference
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Classic single Wishbone cycle; read data lands in rd
  task wb(input logic we, input logic [7:0] adr, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    // Wait for the answer; only the watchdog ends a hang
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  // Offer one operation; returns just after the edge that took it
  task op(input rrr_op_t o, input logic [7:0] lit, input logic [7:0] fd,
          input logic dst, input logic [`RRR_PC_W-1:0] st);
    @(posedge clk_i);
    instr_valid_i <= 1'b1;
    op_i <= o;
    literal_i <= lit;
    file_data_i <= fd;
    dest_i <= dst;
    faddr_i <= 7'h2a;
    stack_top_i <= st;
    // Hold the offer until an edge that sees the executor ready
    do begin
      @(posedge clk_i);
    end while (ready_o !== 1'b1);
    instr_valid_i <= 1'b0;
    #1;
  endtask

  // Return: pop, load, busy for exactly one extra cycle
  task ret_chk(input logic [`RRR_PC_W-1:0] pc, input logic ie);
    chk(stack_pop_o, 1'b1);
    chk(pc_load_o, 1'b1);
    chk(pc_o, pc);
    chk(ready_o, 1'b0);
    chk(glb_ie_o, ie);
    @(posedge clk_i);
    #1;
    chk(ready_o, 1'b1);
    chk(stack_pop_o, 1'b0);
  endtask

  // Reset image and unmapped bus access
  task t_reset;
    chk(ready_o, 1'b1);
    wb(1'b0, `RRR_OFS_PWRCTL, 32'h0);
    chk(rd, 32'h4);
    wb(1'b1, 8'h40, 32'hff);
    wb(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    $display("test reset done");
  endtask

  // Rotates through carry, both directions and destinations
  task t_rot;
    wb(1'b1, `RRR_OFS_STATUS, 32'h6);
    op(RRR_OP_ROT_LEFT, 8'h00, 8'he6, 1'b0, 15'h0);
    chk(work_o, 8'hcc);
    chk(carry_o, 1'b1);
    chk(file_we_o, 1'b0);
    op(RRR_OP_ROT_LEFT, 8'h00, 8'h01, 1'b1, 15'h0);
    chk({file_we_o, file_addr_o, file_wdata_o}, {1'b1, 7'h2a, 8'h03});
    chk({carry_o, work_o}, 9'h0cc);
    @(posedge clk_i);
    #1;
    chk(file_we_o, 1'b0);
    op(RRR_OP_ROT_RIGHT, 8'h00, 8'h81, 1'b1, 15'h0);
    chk(file_wdata_o, 8'h40);
    chk(carry_o, 1'b1);
    op(RRR_OP_ROT_RIGHT, 8'h00, 8'h02, 1'b0, 15'h0);
    chk(work_o, 8'h81);
    chk(carry_o, 1'b0);
    wb(1'b0, `RRR_OFS_STATUS, 32'h0);
    chk(rd, 32'h6);
    $display("test rotate done");
  endtask

  // The three returns and the interrupt enable bit
  task t_ret;
    wb(1'b1, `RRR_OFS_INTCTL, 32'h05);
    op(RRR_OP_RET_SUB, 8'h00, 8'h00, 1'b0, 15'h1234);
    ret_chk(15'h1234, 1'b0);
    op(RRR_OP_RET_INT, 8'h00, 8'h00, 1'b0, 15'h7fff);
    ret_chk(15'h7fff, 1'b1);
    wb(1'b0, `RRR_OFS_INTCTL, 32'h0);
    chk(rd, 32'h85);
    op(RRR_OP_RET_SUB, 8'h00, 8'h00, 1'b0, 15'h0002);
    ret_chk(15'h0002, 1'b1);
    op(RRR_OP_RET_LIT, 8'hff, 8'h00, 1'b0, 15'h0001);
    chk(work_o, 8'hff);
    ret_chk(15'h0001, 1'b1);
    $display("test return done");
  endtask

  // Software reset versus hardware reset
  task t_swrst;
    op(RRR_OP_SW_RESET, 8'h00, 8'h00, 1'b0, 15'h0);
    chk(soft_reset_o, 1'b1);
    chk({work_o, pc_o, glb_ie_o, carry_o}, 25'h0);
    @(posedge clk_i);
    #1;
    chk(soft_reset_o, 1'b0);
    wb(1'b0, `RRR_OFS_PWRCTL, 32'h0);
    chk(rd, 32'h0);
    wb(1'b1, `RRR_OFS_PC, 32'h55);
    wb(1'b0, `RRR_OFS_PC, 32'h0);
    chk(rd, 32'h0);
    @(posedge clk_i);
    rst_i <= 1'b1;
    @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, `RRR_OFS_PWRCTL, 32'h0);
    chk(rd, 32'h4);
    $display("test software reset done");
  endtask

  // Counts, verdict and end of run
  task end_of_test;
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Watchdog against a hung handshake
  initial begin
    #20000;
    n_errors++;
    end_of_test();
  end

  // Main sequence
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_rot();
    t_ret();
    t_swrst();
    end_of_test();
  end
endmodule
